//--- src/lids_defs.svh
// Offsets, field positions, codes and reset values of the init command sequencer
`ifndef LIDS_DEFS_SVH
`define LIDS_DEFS_SVH
// ==========================================
// Register map (byte addresses)
`define LIDS_ADDR_W      16
`define LIDS_OFF_CMD     15'h0000
`define LIDS_OFF_CFG     15'h0004
`define LIDS_OFF_PAD     15'h0008
`define LIDS_OFF_DEVINFO 15'h000C
`define LIDS_OFF_TCAL    15'h0010
`define LIDS_MEM_BIT     15
// ==========================================
// Fields
`define LIDS_MODE_RNG    2:0
`define LIDS_MRS_RNG     15:8
`define LIDS_MRDATA_RNG  23:16
`define LIDS_DAI_BIT     31
`define LIDS_CALIB_RNG   1:0
`define LIDS_INBUF_RNG   17:16
`define LIDS_MFR_RNG     7:0
`define LIDS_REV1_RNG    15:8
`define LIDS_ORG_RNG     23:16
`define LIDS_MR0_DAI     0
`define LIDS_MR0_RZQ_RNG 4:3
// ==========================================
// Codes and reset values
`define LIDS_MODE_NORMAL 3'h0
`define LIDS_MODE_NOP    3'h1
`define LIDS_MODE_LPCMD  3'h7
`define LIDS_IDX_MR0     8'h00
`define LIDS_IDX_MR1     8'h01
`define LIDS_IDX_MR2     8'h02
`define LIDS_IDX_MR3     8'h03
`define LIDS_IDX_MFR     8'h05
`define LIDS_IDX_REV1    8'h06
`define LIDS_IDX_ORG     8'h08
`define LIDS_IDX_ZQ      8'h0A
`define LIDS_IDX_PASR    8'h10
`define LIDS_IDX_RESET   8'h3F
`define LIDS_CALIB_INIT  2'h3
`define LIDS_INBUF_OPEN  2'h3
`define LIDS_RST_MODE    3'h1
`endif

//--- src/lids_pkg.sv
// Types shared by the init command sequencer and its link stage
package lids_pkg;
	typedef enum logic [2:0] {
		LIDS_CMD_NOP   = 3'h1,
		LIDS_CMD_RESET = 3'h2,
		LIDS_CMD_ZQCAL = 3'h3,
		LIDS_CMD_MRW   = 3'h4,
		LIDS_CMD_MRR   = 3'h5
	} lids_cmd_t;

	typedef enum logic [3:0] {
		LK_IDLE  = 4'h1,
		LK_WAIT  = 4'h2,
		LK_DRIVE = 4'h4,
		LK_CAPT  = 4'h8
	} lids_lk_st_t;

	typedef struct packed {
		logic [2:0]  ck_sync;
		logic        lvl;
		logic [7:0]  dq1;
		logic [7:0]  dq2;
		logic [7:0]  dq3;
		lids_lk_st_t st;
		lids_cmd_t   cmd;
		logic [7:0]  ma;
		logic [7:0]  op;
		logic        vld;
		logic        oe;
		logic        rvld;
		logic [7:0]  rdata;
	} lids_lk_state_t;

	typedef struct packed {
		logic [2:0]  mode;
		logic [7:0]  mode_reg_index;
		logic [7:0]  mrdata;
		logic        auto_init_flag;
		logic [1:0]  calib;
		logic [1:0]  inbuf;
		logic [23:0] devinfo;
		logic [1:0]  zqr;
		logic [31:0] rdata;
		logic        err;
		logic        start;
		lids_cmd_t   cmd;
		logic [7:0]  op;
		logic        dwr;
		logic [14:0] daddr;
		logic [31:0] dwdata;
	} lids_state_t;
endpackage

//--- src/lids_cmd_link.sv
// Link stage: holds one command on the memory pins from one link clock rise to the next
`timescale 1ns/10ps
`include "lids_defs.svh"
module lids_cmd_link (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset_n,
	// Request from the sequencer
	input  wire logic               start,
	input  wire lids_pkg::lids_cmd_t cmd_in,
	input  wire logic [7:0]         ma_in,
	input  wire logic [7:0]         op_in,
	output logic                    busy,
	// Memory pins
	input  wire logic               link_ck,
	output lids_pkg::lids_cmd_t     mem_cmd,
	output logic                    mem_cmd_vld,
	output logic [7:0]              mem_ma,
	input  wire logic [7:0]         mem_dq_in,
	output logic [7:0]              mem_dq_out,
	output logic                    mem_dq_oe,
	// Mode-register read return
	output logic                    rd_vld,
	output logic [7:0]              rd_idx,
	output logic [7:0]              rd_data
);
	import lids_pkg::*;

	lids_lk_state_t q;
	lids_lk_state_t d;
	logic           rise;

	// ==========================================
	// Edge finder: a rise counts once stages two and three agree high
	assign rise = (q.ck_sync[1] == q.ck_sync[2]) && q.ck_sync[2] && !q.lvl;

	always_comb begin
		d = q;
		d.rvld = 1'b0;
		d.ck_sync = {q.ck_sync[1:0], link_ck};
		if (q.ck_sync[1] == q.ck_sync[2]) begin
			d.lvl = q.ck_sync[2];
		end
		d.dq1 = mem_dq_in;
		d.dq2 = q.dq1;
		d.dq3 = q.dq2;
		unique case (q.st)
			LK_IDLE: begin
				if (start) begin
					d.cmd = cmd_in;
					d.ma = ma_in;
					d.op = op_in;
					d.st = LK_WAIT;
				end
			end
			LK_WAIT: begin
				if (rise) begin
					d.vld = 1'b1;
					d.oe = (q.cmd == LIDS_CMD_MRW) || (q.cmd == LIDS_CMD_ZQCAL);
					d.st = LK_DRIVE;
				end
			end
			LK_DRIVE: begin
				if (rise) begin
					d.vld = 1'b0;
					d.oe = 1'b0;
					d.st = (q.cmd == LIDS_CMD_MRR) ? LK_CAPT : LK_IDLE;
				end
			end
			LK_CAPT: begin
				// Data must be settled a whole link cycle; bus is not deskewed
				if (rise) begin
					d.rdata = q.dq3;
					d.rvld = 1'b1;
					d.st = LK_IDLE;
				end
			end
			default: d.st = LK_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q <= '0;
			q.st <= LK_IDLE;
			q.cmd <= LIDS_CMD_NOP;
		end else begin
			q <= d;
		end
	end

	assign busy = (q.st != LK_IDLE) || start;
	assign mem_cmd = q.cmd;
	assign mem_cmd_vld = q.vld;
	assign mem_ma = q.ma;
	assign mem_dq_out = q.op;
	assign mem_dq_oe = q.oe;
	assign rd_vld = q.rvld;
	assign rd_idx = q.ma;
	assign rd_data = q.rdata;

	// ==========================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_drive_with_cmd: assert property (mem_dq_oe |-> mem_cmd_vld && mem_cmd != LIDS_CMD_MRR)
		else $error("data driven outside a write command");
	chk_issue_on_edge: assert property ($rose(mem_cmd_vld) |-> $past(rise) && $past(q.st) == LK_WAIT)
		else $error("command issued off a link edge");
endmodule

//--- src/lids_init_seq.sv
// Init command sequencer: APB registers, acknowledge decode and result capture
// How it works
// - A pending command goes out only when software writes anywhere in memory space.
// - Command mode with index 63 issues the memory reset command on acknowledge.
// - Index 10 issues ZQ calibration carrying the calibration type; software then sets 2.
// - Indexes 1, 2, 3 issue mode-register writes with the programmed operand.
// - Index 16 issues a mode-register write for partial array self refresh.
// - Command select 1 issues a NOP on the acknowledging write.
// - Read of index 5 stores the maker code in the device information register.
// - Read of index 6 stores revision one in the device information register.
// - Read of index 8 stores memory organisation in the device information register.
// - Read of index 0 stores resistor info and the auto-init flag.
// - Writing normal mode ends initialisation; memory writes, the next one included, pass through.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "lids_defs.svh"
module lids_init_seq (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     reset_n,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`LIDS_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Memory link
	input  wire logic                     link_ck,
	output lids_pkg::lids_cmd_t           mem_cmd,
	output logic                          mem_cmd_vld,
	output logic [7:0]                    mem_ma,
	input  wire logic [7:0]               mem_dq_in,
	output logic [7:0]                    mem_dq_out,
	output logic                          mem_dq_oe,
	// Normal-mode write port
	output logic                          data_wr,
	output logic [`LIDS_ADDR_W-2:0]       data_addr,
	output logic [31:0]                   data_wdata,
	// Pad control
	output logic [1:0]                    in_buf_en
);
	import lids_pkg::*;

	lids_state_t     s_q;
	lids_state_t     s_d;
	logic            link_busy;
	logic            rd_vld;
	logic [7:0]      rd_idx;
	logic [7:0]      rd_data;
	logic            setup;
	logic            access;
	logic            is_mem;
	logic            ack;
	logic            reg_wr;
	logic            cmd_pending;
	logic [14:0]     off;
	lids_cmd_t       dec_cmd;

	// ==========================================
	// Bus decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign is_mem = paddr[`LIDS_MEM_BIT];
	assign off = paddr[`LIDS_ADDR_W-2:0];
	assign cmd_pending = (s_q.mode != `LIDS_MODE_NORMAL);
	// Acknowledge stalls while the link still holds the previous command
	assign pready = !(access && is_mem && pwrite && cmd_pending && link_busy);
	assign ack = access && pready && pwrite && is_mem;
	assign reg_wr = access && pready && pwrite && !is_mem;

	// ==========================================
	// Command decode from mode and index
	always_comb begin
		dec_cmd = LIDS_CMD_NOP;
		if (s_q.mode == `LIDS_MODE_LPCMD) begin
			unique case (s_q.mode_reg_index)
				`LIDS_IDX_RESET: dec_cmd = LIDS_CMD_RESET;
				`LIDS_IDX_ZQ:    dec_cmd = LIDS_CMD_ZQCAL;
				`LIDS_IDX_MR0,
				`LIDS_IDX_MFR,
				`LIDS_IDX_REV1,
				`LIDS_IDX_ORG:   dec_cmd = LIDS_CMD_MRR;
				default:         dec_cmd = LIDS_CMD_MRW;
			endcase
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.dwr = 1'b0;
		if (setup) begin
			s_d.err = 1'b0;
			s_d.rdata = '0;
			if (!is_mem) begin
				unique case (off)
					`LIDS_OFF_CMD: begin
						s_d.rdata[`LIDS_MODE_RNG] = s_q.mode;
						s_d.rdata[`LIDS_MRS_RNG] = s_q.mode_reg_index;
						s_d.rdata[`LIDS_MRDATA_RNG] = s_q.mrdata;
						s_d.rdata[`LIDS_DAI_BIT] = s_q.auto_init_flag;
					end
					`LIDS_OFF_CFG:     s_d.rdata[`LIDS_CALIB_RNG] = s_q.calib;
					`LIDS_OFF_PAD:     s_d.rdata[`LIDS_INBUF_RNG] = s_q.inbuf;
					`LIDS_OFF_DEVINFO: s_d.rdata[23:0] = s_q.devinfo;
					`LIDS_OFF_TCAL:    s_d.rdata[1:0] = s_q.zqr;
					default:           s_d.err = 1'b1;
				endcase
			end
		end
		if (reg_wr) begin
			unique case (off)
				`LIDS_OFF_CMD: begin
					s_d.mode = pwdata[`LIDS_MODE_RNG];
					s_d.mode_reg_index = pwdata[`LIDS_MRS_RNG];
					s_d.mrdata = pwdata[`LIDS_MRDATA_RNG];
				end
				`LIDS_OFF_CFG: s_d.calib = pwdata[`LIDS_CALIB_RNG];
				`LIDS_OFF_PAD: s_d.inbuf = pwdata[`LIDS_INBUF_RNG];
				default: ;
			endcase
		end
		if (ack) begin
			if (cmd_pending) begin
				// Only NOP and command modes reach the pins; other codes just acknowledge
				s_d.start = (s_q.mode == `LIDS_MODE_NOP) || (s_q.mode == `LIDS_MODE_LPCMD);
				s_d.cmd = dec_cmd;
				s_d.op = (dec_cmd == LIDS_CMD_ZQCAL) ? {6'h00, s_q.calib} : s_q.mrdata;
			end else begin
				s_d.dwr = 1'b1;
				s_d.daddr = off;
				s_d.dwdata = pwdata;
			end
		end
		// Closed input buffers read back as zero
		if (rd_vld) begin
			unique case (rd_idx)
				`LIDS_IDX_MFR:  s_d.devinfo[`LIDS_MFR_RNG] = (s_q.inbuf == `LIDS_INBUF_OPEN) ? rd_data : 8'h00;
				`LIDS_IDX_REV1: s_d.devinfo[`LIDS_REV1_RNG] = (s_q.inbuf == `LIDS_INBUF_OPEN) ? rd_data : 8'h00;
				`LIDS_IDX_ORG:  s_d.devinfo[`LIDS_ORG_RNG] = (s_q.inbuf == `LIDS_INBUF_OPEN) ? rd_data : 8'h00;
				`LIDS_IDX_MR0: begin
					s_d.zqr = (s_q.inbuf == `LIDS_INBUF_OPEN) ? rd_data[`LIDS_MR0_RZQ_RNG] : 2'h0;
					s_d.auto_init_flag = (s_q.inbuf == `LIDS_INBUF_OPEN) && rd_data[`LIDS_MR0_DAI];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.mode <= `LIDS_RST_MODE;
			s_q.cmd <= LIDS_CMD_NOP;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Link stage
	lids_cmd_link u_link (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.start       (s_q.start),
		.cmd_in      (s_q.cmd),
		.ma_in       (s_q.mode_reg_index),
		.op_in       (s_q.op),
		.busy        (link_busy),
		.link_ck     (link_ck),
		.mem_cmd     (mem_cmd),
		.mem_cmd_vld (mem_cmd_vld),
		.mem_ma      (mem_ma),
		.mem_dq_in   (mem_dq_in),
		.mem_dq_out  (mem_dq_out),
		.mem_dq_oe   (mem_dq_oe),
		.rd_vld      (rd_vld),
		.rd_idx      (rd_idx),
		.rd_data     (rd_data)
	);

	assign prdata = s_q.rdata;
	assign pslverr = s_q.err && access;
	assign data_wr = s_q.dwr;
	assign data_addr = s_q.daddr;
	assign data_wdata = s_q.dwdata;
	assign in_buf_en = s_q.inbuf;

	// ==========================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_ack_starts_cmd: assert property (ack && s_q.mode == `LIDS_MODE_LPCMD |=> s_q.start ##1 link_busy)
		else $error("acknowledge did not start a command");
	chk_no_cmd_unacked: assert property (s_q.start |-> $past(ack) && $past(cmd_pending))
		else $error("command started without acknowledge");
	chk_reset_cmd: assert property (ack && cmd_pending && s_q.mode_reg_index == `LIDS_IDX_RESET
		&& s_q.mode == `LIDS_MODE_LPCMD |=> s_q.cmd == LIDS_CMD_RESET)
		else $error("reset command not selected");
	chk_zq_operand: assert property (ack && s_q.mode == `LIDS_MODE_LPCMD && s_q.mode_reg_index == `LIDS_IDX_ZQ
		|=> s_q.cmd == LIDS_CMD_ZQCAL && s_q.op[1:0] == $past(s_q.calib))
		else $error("calibration command or type wrong");
	chk_mrw_index: assert property (ack && s_q.mode == `LIDS_MODE_LPCMD && (s_q.mode_reg_index == `LIDS_IDX_MR2
		|| s_q.mode_reg_index == `LIDS_IDX_PASR) |=> s_q.cmd == LIDS_CMD_MRW && s_q.op == $past(s_q.mrdata))
		else $error("mode-register write not issued");
	chk_nop_cmd: assert property (ack && s_q.mode == `LIDS_MODE_NOP |=> s_q.start && s_q.cmd == LIDS_CMD_NOP)
		else $error("NOP not issued");
	chk_mfr_store: assert property (rd_vld && rd_idx == `LIDS_IDX_MFR && s_q.inbuf == `LIDS_INBUF_OPEN
		|=> s_q.devinfo[`LIDS_MFR_RNG] == $past(rd_data))
		else $error("maker code not stored");
	chk_rev_store: assert property (rd_vld && rd_idx == `LIDS_IDX_REV1 && s_q.inbuf == `LIDS_INBUF_OPEN
		|=> s_q.devinfo[`LIDS_REV1_RNG] == $past(rd_data))
		else $error("revision not stored");
	chk_org_store: assert property (rd_vld && rd_idx == `LIDS_IDX_ORG && s_q.inbuf == `LIDS_INBUF_OPEN
		|=> s_q.devinfo[`LIDS_ORG_RNG] == $past(rd_data))
		else $error("organisation not stored");
	chk_mr0_store: assert property (rd_vld && rd_idx == `LIDS_IDX_MR0 && s_q.inbuf == `LIDS_INBUF_OPEN
		|=> s_q.auto_init_flag == $past(rd_data[`LIDS_MR0_DAI]))
		else $error("auto-init flag not stored");
	chk_normal_pass: assert property (ack && !cmd_pending |=> data_wr && !s_q.start)
		else $error("normal-mode write not passed through");
	chk_no_data_in_cmd: assert property (ack && cmd_pending |=> !data_wr)
		else $error("data write leaked in command mode");

	cov_reset_issued: cover property (mem_cmd_vld && mem_cmd == LIDS_CMD_RESET);
	cov_mrr_return: cover property (rd_vld && rd_idx == `LIDS_IDX_MFR);
	cov_ack_stall: cover property (access && !pready);
	cov_normal_write: cover property (data_wr);
endmodule

//--- verification/lids_mem_model.sv
// Behavioural memory device on the far side of the command link
`timescale 1ns/10ps
module lids_mem_model #(
	parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] REV_ID   = 8'h21, // Arbitrary value
	parameter logic [7:0] ORG_ID   = 8'h47,
	parameter logic [7:0] MR0_VAL  = 8'h11
) (
	// Link pins
	output logic                     link_ck,
	input  wire lids_pkg::lids_cmd_t mem_cmd,
	input  wire logic                mem_cmd_vld,
	input  wire logic [7:0]          mem_ma,
	input  wire logic [7:0]          mem_dq_out,
	input  wire logic                mem_dq_oe,
	output logic [7:0]               mem_dq_in,
	// Observation
	output logic [2:0]               last_cmd,
	output logic [7:0]               last_ma,
	output logic [7:0]               last_op,
	output logic [7:0]               cmd_count
);
	import lids_pkg::*;
	int hold;
	// ==========================================
	// Memory clock runs free, as a memory clock does
	initial begin
		link_ck = 1'b0;
		mem_dq_in = 8'hA5;
		hold = 0;
		cmd_count = 8'h00;
		forever #160 link_ck = ~link_ck;
	end
	// ==========================================
	// Command capture and read answers
	always @(posedge link_ck) begin
		if (mem_cmd_vld === 1'b1) begin
			cmd_count <= cmd_count + 8'h01;
			last_cmd  <= mem_cmd;
			last_ma   <= mem_ma;
			last_op   <= mem_dq_oe ? mem_dq_out : 8'h00;
		end
		if (mem_cmd_vld === 1'b1 && mem_cmd == LIDS_CMD_MRR) begin
			hold <= 2;
			case (mem_ma)
				8'h05: mem_dq_in <= MAKER_ID;
				8'h06: mem_dq_in <= REV_ID;
				8'h08: mem_dq_in <= ORG_ID;
				8'h00: mem_dq_in <= MR0_VAL;
				default: mem_dq_in <= ~mem_dq_in;
			endcase
		end else if (hold > 0) begin
			hold <= hold - 1;
		end else begin
			// Released bus toggles so stale data never reads as good
			mem_dq_in <= ~mem_dq_in;
		end
	end
endmodule

//--- verification/test_lids_init_seq.sv
// Self-checking bench for the init command sequencer
`timescale 1ns/10ps
`include "lids_defs.svh"
module test_lids_init_seq;
	import lids_pkg::*;
	localparam logic [7:0] MAKER = 8'h5A;
	localparam logic [7:0] REV   = 8'h21;
	localparam logic [7:0] ORG   = 8'h47;
	localparam logic [7:0] MR0   = 8'h11;
	localparam int         INIT5 = 50; // Stand-in for the fifth init interval
	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, link_ck;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, data_wdata, wr_data, r;
	lids_cmd_t   mem_cmd;
	logic        mem_cmd_vld, mem_dq_oe, data_wr, e;
	logic [7:0]  mem_ma, mem_dq_in, mem_dq_out, last_ma, last_op, cmd_count;
	logic [14:0] data_addr, wr_addr;
	logic [2:0]  last_cmd;
	logic [1:0]  in_buf_en;
	int          fail_count, compares, cycles, wr_seen, n0;
	lids_init_seq dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_ck(link_ck), .mem_cmd(mem_cmd), .mem_cmd_vld(mem_cmd_vld),
		.mem_ma(mem_ma), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
		.data_wr(data_wr), .data_addr(data_addr), .data_wdata(data_wdata), .in_buf_en(in_buf_en));
	lids_mem_model #(.MAKER_ID(MAKER), .REV_ID(REV), .ORG_ID(ORG), .MR0_VAL(MR0)) mem (
		.link_ck(link_ck), .mem_cmd(mem_cmd), .mem_cmd_vld(mem_cmd_vld), .mem_ma(mem_ma),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in),
		.last_cmd(last_cmd), .last_ma(last_ma), .last_op(last_op), .cmd_count(cmd_count));
	// ==========================================
	// Clock, timeout and write-port monitor
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			stop_test();
		end
		if (data_wr === 1'b1) begin
			wr_seen <= wr_seen + 1;
			wr_addr <= data_addr;
			wr_data <= data_wdata;
		end
	end
	// ==========================================
	// Helpers
	task stop_test;
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Stalls last while the link still holds a command; only the bench timeout ends a hang
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic issue(input logic [2:0] mode, input logic [7:0] idx, input logic [7:0] op, input int gap);
		logic [7:0] c0;
		int         n;
		wr(`LIDS_OFF_CMD, {8'h00, op, idx, 5'h00, mode});
		apb(1'b0, `LIDS_OFF_CMD, 32'h0, r, e);
		check({8'h00, r[23:8], 5'h00, r[2:0]}, {8'h00, op, idx, 5'h00, mode}, "readback");
		c0 = cmd_count;
		repeat (gap) @(posedge core_clk);
		check(cmd_count, c0, "sent before acknowledge");
		wr(16'h8000, 32'h0);
		n = 0;
		while (cmd_count === c0 && n < 300 && mode != 3'h0) begin
			@(posedge core_clk);
			n++;
		end
		if (mode == 3'h0) repeat (100) @(posedge core_clk);
		check(cmd_count, (mode == 3'h0) ? c0 : c0 + 8'h01, "command count");
	endtask
	task automatic mrr(input logic [7:0] idx, input logic [15:0] a);
		issue(3'h7, idx, 8'h00, 0);
		check(last_cmd, LIDS_CMD_MRR, "read command");
		repeat (30) @(posedge core_clk);
		apb(1'b0, a, 32'h0, r, e);
	endtask
	// ==========================================
	// Scenarios
	task t_reset_and_gate;
		apb(1'b0, `LIDS_OFF_CMD, 32'h0, r, e);
		check(r[2:0], `LIDS_RST_MODE, "mode after reset");
		apb(1'b0, 16'h0014, 32'h0, r, e);
		check(e, 1'b1, "unmapped offset");
		issue(3'h7, `LIDS_IDX_RESET, 8'h00, 200);
		check(last_cmd, LIDS_CMD_RESET, "reset command");
		check(wr_seen, 0, "acknowledge passed as data");
		repeat (INIT5) @(posedge core_clk);
	endtask
	task t_zq_and_mrw;
		logic [7:0] idx [4];
		idx = '{8'h01, 8'h02, 8'h03, 8'h10};
		wr(`LIDS_OFF_CFG, 32'h3);
		issue(3'h7, `LIDS_IDX_ZQ, 8'h00, 0);
		check({last_cmd, last_ma, last_op[1:0]}, {LIDS_CMD_ZQCAL, 8'h0A, 2'h3}, "calibration");
		wr(`LIDS_OFF_CFG, 32'h2);
		apb(1'b0, `LIDS_OFF_CFG, 32'h0, r, e);
		check(r[1:0], 2'h2, "calibration type");
		foreach (idx[i]) begin
			issue(3'h7, idx[i], idx[i] ^ 8'hC3, 0);
			check({last_cmd, last_ma, last_op}, {LIDS_CMD_MRW, idx[i], idx[i] ^ 8'hC3}, "write");
		end
	endtask
	task t_nop_and_reads;
		wr(`LIDS_OFF_PAD, 32'h0003_0000);
		@(posedge core_clk);
		check(in_buf_en, 2'h3, "input buffers");
		issue(3'h1, 8'h00, 8'h00, 0);
		check(last_cmd, LIDS_CMD_NOP, "nop");
		mrr(`LIDS_IDX_MFR, `LIDS_OFF_DEVINFO);
		check(r[7:0], MAKER, "maker");
		mrr(`LIDS_IDX_REV1, `LIDS_OFF_DEVINFO);
		check(r[15:8], REV, "revision");
		mrr(`LIDS_IDX_ORG, `LIDS_OFF_DEVINFO);
		check(r[23:16], ORG, "organisation");
		mrr(`LIDS_IDX_MR0, `LIDS_OFF_TCAL);
		check(r[1:0], MR0[4:3], "resistor info");
		apb(1'b0, `LIDS_OFF_CMD, 32'h0, r, e);
		check(r[31], MR0[0], "auto-init flag");
	endtask
	task t_normal;
		// Modes other than normal, NOP and command only acknowledge
		wr(`LIDS_OFF_CMD, 32'h0000_0002);
		n0 = cmd_count;
		wr(16'h8000, 32'h0);
		repeat (30) @(posedge core_clk);
		check(cmd_count, n0, "idle mode issued a command");
		check(wr_seen, 0, "data before normal mode");
		issue(3'h0, 8'h00, 8'h00, 0);
		n0 = wr_seen;
		wr(16'h8124, 32'h1234_5678);
		repeat (3) @(posedge core_clk);
		check(wr_seen, n0 + 1, "data write count");
		check({wr_addr, wr_data}, {15'h0124, 32'h1234_5678}, "data write");
	endtask
	// ==========================================
	// Main sequence
	initial begin
		reset_n    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 16'h0000;
		pwdata     = 32'h0;
		fail_count = 0;
		compares   = 0;
		cycles     = 0;
		wr_seen    = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset_and_gate();
		t_zq_and_mrw();
		t_nop_and_reads();
		t_normal();
		stop_test();
	end
endmodule
